//--- design/dccsp_map.svh
// offsets, field positions, reset values and counts of the codec port
`ifndef DCCSP_MAP_SVH
`define DCCSP_MAP_SVH
// external register addresses on the 3-bit core bus
`define DCCSP_ADDR_CH0    3'h5
`define DCCSP_ADDR_CH1    3'h6
`define DCCSP_ADDR_CFG    3'h7
// codec control word fields (configuration stage two)
`define DCCSP_EN0_BIT     0
`define DCCSP_EN1_BIT     1
`define DCCSP_MODE_LO     2
`define DCCSP_MODE_HI     3
`define DCCSP_PS_LO       4
`define DCCSP_PS_HI       7
`define DCCSP_MULAW_BIT   8
// reset values
`define DCCSP_CFG_RST     16'h0000
`define DCCSP_DATA_RST    16'h0000
// frame counts: top bit index per mode, and 64-bit half point
`define DCCSP_TOP8        6'h07
`define DCCSP_TOP16       6'h0f
`define DCCSP_TOP64       6'h3f
`define DCCSP_HALF64      6'h20
// prescaler wrap value
`define DCCSP_PS_WRAP     4'hf
`endif

//--- design/dccsp_pkg.sv
// types of the dual channel codec serial port
`default_nettype none
package dccsp_pkg;
  // frame length modes
  typedef enum logic [1:0] {
    DCCSP_M8  = 2'b00,
    DCCSP_M16 = 2'b01,
    DCCSP_M64 = 2'b10
  } dccsp_mode_t;
  // frame sequencer states, gray along idle-shift-gap
  typedef enum logic [1:0] {
    DCCSP_IDLE  = 2'b00,
    DCCSP_SHIFT = 2'b01,
    DCCSP_GAP   = 2'b11
  } dccsp_state_t;
endpackage : dccsp_pkg
`default_nettype wire

//--- design/dccsp_top.sv
// codec serial port: write fifo, buffers, clock divider, frame sequencer
`timescale 1ns/100ps
`default_nettype none
`include "dccsp_map.svh"

////////////////////////////////////////////////////////////////////////////
// write fifo: holds queued data writes until the shifter is idle
module dccsp_fifo #(
  parameter int W  = 17,
  parameter int D  = 16,
  parameter int AW = 4
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  // fill side
  input  wire logic          in_valid,
  output var  logic          in_ready,
  input  wire logic [W-1:0]  in_data,
  // drain side
  output var  logic          out_valid,
  input  wire logic          out_ready,
  output logic      [W-1:0]  out_data
);
  logic [W-1:0]  mem [D];   // storage
  logic [AW-1:0] wp;        // write pointer
  logic [AW-1:0] rp;        // read pointer
  logic [AW:0]   cnt;       // fill level
  logic [AW:0]   next_cnt;  // fill level after this cycle
  logic          push;      // word taken
  logic          pop;       // word given

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rp];

  // next fill level
  always_comb begin
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      next_cnt = cnt - (AW+1)'(1);
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // pointers, level and registered flags
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wp        <= '0;
      rp        <= '0;
      cnt       <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp <= wp + AW'(1);
      end
      if (pop) begin
        rp <= rp + AW'(1);
      end
      cnt       <= next_cnt;
      in_ready  <= (next_cnt != (AW+1)'(D));  // honest full
      out_valid <= (next_cnt != '0);          // honest empty
    end
  end
endmodule : dccsp_fifo

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - serial clock is clk/2 over two's-complement prescale
// - transmit bit on rising sclk, msb first
// - sample receive bit on falling sclk, msb first
// - frame sync high for the whole channel transfer
// - frame-end interrupt with frame_sync_second falling edge
// - port disabled after reset
// - port owns irq vector while enabled
// - low irq pin adds one interrupt at enable
// - data and config addresses are two-stage buffers
// - data write pushes stage two, loads new word
// - frames repeat continuously while the port is enabled
// - stage two is shift register in 8/16
// - eight-bit mode uses the low byte
// - 64-bit order ch0s1, ch0s2, ch1s1, ch1s2
// - channel 0 first sync, channel 1 second sync
// - master only, always drives clock and syncs
// - disabled channel address freed for external use
module dccsp_top
  import dccsp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // core external-register bus
  input  wire logic [2:0]  ext_addr,
  input  wire logic        ext_wr,
  input  wire logic        ext_rd,
  input  wire logic [15:0] ext_wdata,
  output logic      [15:0] ext_rdata,
  output wire logic        ext_wait_n,
  // codec link
  output logic             sclk,
  output logic             txd,
  input  wire logic        rxd,
  output logic             frame_sync_first,
  output logic             frame_sync_second,
  // interrupt line and vector ownership
  input  wire logic        frame_end_irq_line,
  output logic             codec_irq,
  output logic             int_vector_owned,
  // side outputs of the control words
  output logic      [1:0]  chan_ext_free,
  output logic      [15:0] wait_state_cfg,
  output logic             mulaw_sel
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0]  cfg_s1;          // config stage one (wait states)
  logic [15:0]  cfg_s2;          // config stage two (codec control)
  logic [15:0]  dbuf [4];        // {chan,stage2} indexed data words
  logic [3:0]   pcnt;            // prescale up-counter
  logic         tick;            // prescale wrap
  logic         rise;            // sclk goes high this edge
  logic         fall;            // sclk goes low this edge
  dccsp_state_t st;              // sequencer state
  logic [5:0]   cnt;             // bit index within frame
  logic         chan;            // channel of current frame
  logic         next_chan;       // channel of next frame
  logic [5:0]   top;             // first bit index of a frame
  logic         port_en;         // any channel enabled
  logic         port_en_d;       // port_en one cycle ago
  logic         en0;             // channel 0 enable
  logic         en1;             // channel 1 enable
  dccsp_mode_t  mode;            // frame length mode
  logic [3:0]   ps;              // prescaler setting
  logic         f_valid;         // fifo has a queued write
  logic         f_pop;           // apply queued write now
  logic [16:0]  f_data;          // {chan, word}
  logic         f_push;          // bus write to an enabled channel

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // word slot of a bit: 64-bit walks all four stages
  function automatic logic [1:0] slot(dccsp_mode_t m, logic c,
                                      logic [5:0] n);
    if (m == DCCSP_M64) begin
      slot = 2'h3 - n[5:4];
    end else begin
      slot = {c, 1'b1};
    end
  endfunction : slot

  // first bit index of a frame for a mode
  function automatic logic [5:0] frame_top(dccsp_mode_t m);
    case (m)
      DCCSP_M8:  frame_top = `DCCSP_TOP8;
      DCCSP_M16: frame_top = `DCCSP_TOP16;
      DCCSP_M64: frame_top = `DCCSP_TOP64;
      default:   frame_top = `DCCSP_TOP16;
    endcase
  endfunction : frame_top

  // control word decode
  assign en0     = cfg_s2[`DCCSP_EN0_BIT];
  assign en1     = cfg_s2[`DCCSP_EN1_BIT];
  assign mode    = dccsp_mode_t'(cfg_s2[`DCCSP_MODE_HI:`DCCSP_MODE_LO]);
  assign ps      = cfg_s2[`DCCSP_PS_HI:`DCCSP_PS_LO];
  assign port_en = en0 | en1;
  assign top     = frame_top(mode);

  ////////////////////////////////////////////////////////////////////////
  // configuration: two-stage, each write pushes stage one into two
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_s1 <= `DCCSP_CFG_RST;
      cfg_s2 <= `DCCSP_CFG_RST;
    end else if (ext_wr && ext_addr == `DCCSP_ADDR_CFG) begin
      cfg_s2 <= cfg_s1;
      cfg_s1 <= ext_wdata;
    end
  end

  // registered copies of control fields
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chan_ext_free  <= 2'h3;
      wait_state_cfg <= `DCCSP_CFG_RST;
      mulaw_sel      <= 1'b0;
    end else begin
      chan_ext_free  <= {~en1, ~en0};
      wait_state_cfg <= cfg_s1;
      mulaw_sel      <= cfg_s2[`DCCSP_MULAW_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data writes queue here; drained only outside a shift
  assign f_push = ext_wr &&
                  ((ext_addr == `DCCSP_ADDR_CH0 && en0) ||
                   (ext_addr == `DCCSP_ADDR_CH1 && en1));
  assign f_pop  = f_valid && st != DCCSP_SHIFT && !rise;

  dccsp_fifo #(
    .W  (17),
    .D  (16),
    .AW (4)
  ) u_wfifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (f_push),
    .in_ready  (ext_wait_n),
    .in_data   ({ext_addr == `DCCSP_ADDR_CH1, ext_wdata}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // serial clock: up-counter from setting to wrap, toggle on wrap
  assign tick = (pcnt == `DCCSP_PS_WRAP);
  assign rise = tick & ~sclk;
  assign fall = tick & sclk;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pcnt <= 4'h0;
      sclk <= 1'b0;
    end else if (!port_en) begin
      pcnt <= ps;  // held while disabled
      sclk <= 1'b0;
    end else if (tick) begin
      pcnt <= ps;
      sclk <= ~sclk;
    end else begin
      pcnt <= pcnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data buffers: queued writes and received bits
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        dbuf[i] <= `DCCSP_DATA_RST;
      end
    end else if (f_pop) begin
      dbuf[{f_data[16], 1'b0}] <= dbuf[{f_data[16], 1'b1}];
      dbuf[{f_data[16], 1'b1}] <= f_data[15:0];
    end else if (st == DCCSP_SHIFT && fall) begin
      dbuf[slot(mode, chan, cnt)][cnt[3:0]] <= rxd;
    end
  end

  // register reads return stage one
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_rdata <= 16'h0000;
    end else if (ext_rd) begin
      case (ext_addr)
        `DCCSP_ADDR_CH0: ext_rdata <= en0 ? dbuf[0] : 16'h0000;
        `DCCSP_ADDR_CH1: ext_rdata <= en1 ? dbuf[2] : 16'h0000;
        `DCCSP_ADDR_CFG: ext_rdata <= cfg_s1;
        default:         ext_rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel for the next frame: alternate when both are enabled, always channel 0 in 64-bit mode
  always_comb begin
    next_chan = 1'b0;
    if (mode == DCCSP_M64) begin
      next_chan = 1'b0;
    end else if (en0 && en1) begin
      next_chan = (st == DCCSP_IDLE) ? 1'b0 : ~chan;
    end else begin
      next_chan = en1;
    end
  end

  // frame sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !port_en) begin
      st                <= DCCSP_IDLE;
      cnt               <= 6'h00;
      chan              <= 1'b0;
      txd               <= 1'b0;
      frame_sync_first  <= 1'b0;
      frame_sync_second <= 1'b0;
    end else begin
      case (st)
        DCCSP_IDLE, DCCSP_GAP: begin
          if (rise) begin
            // open a frame, restarting forever while enabled
            st   <= DCCSP_SHIFT;
            cnt  <= top;
            chan <= next_chan;
            txd  <= dbuf[slot(mode, next_chan, top)][top[3:0]];
            frame_sync_first  <= ~next_chan;
            frame_sync_second <= next_chan;
          end
        end
        DCCSP_SHIFT: begin
          if (rise) begin
            if (cnt == 6'h00) begin
              // close the frame
              st                <= DCCSP_GAP;
              frame_sync_first  <= 1'b0;
              frame_sync_second <= 1'b0;
            end else begin
              cnt <= cnt - 6'h01;
              txd <= dbuf[slot(mode, chan, cnt - 6'h01)]
                         [4'(cnt - 6'h01)];
              if (mode == DCCSP_M64 && cnt == `DCCSP_HALF64) begin
                // second half of the long frame on the second sync
                frame_sync_first  <= 1'b0;
                frame_sync_second <= 1'b1;
              end
            end
          end
        end
        default: begin
          st <= DCCSP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt: frame end, plus once at enable when the pin is low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      port_en_d        <= 1'b0;
      codec_irq        <= 1'b0;
      int_vector_owned <= 1'b0;
    end else begin
      port_en_d        <= port_en;
      int_vector_owned <= port_en;
      codec_irq        <= (port_en && st == DCCSP_SHIFT && rise &&
                           cnt == 6'h00 && frame_sync_second) ||
                          (port_en && !port_en_d &&
                           !frame_end_irq_line);
    end
  end
endmodule : dccsp_top
`default_nettype wire

//--- tb/dccsp_props.sv
// pin-level assertions of the codec serial port
`timescale 1ns/100ps
`default_nettype none
module dccsp_props (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // register bus
  input wire logic        ext_rd,
  input wire logic [15:0] ext_rdata,
  input wire logic        ext_wait_n,
  // codec link
  input wire logic        sclk,
  input wire logic        txd,
  input wire logic        frame_sync_first,
  input wire logic        frame_sync_second,
  // interrupt and ownership
  input wire logic        frame_end_irq_line,
  input wire logic        codec_irq,
  input wire logic        int_vector_owned,
  input wire logic [1:0]  chan_ext_free
);
  // one clock domain, reset cuts every check
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  AST_RST_IDLE:
    assert property ($fell(sys_rst) |-> !sclk && chan_ext_free == 2'h3)
    else $error("port busy after reset");
  AST_OFF_QUIET:
    assert property ((chan_ext_free == 2'h3) [*2] |-> !sclk && !txd)
    else $error("link active while off");
  AST_SYNC_APART:
    assert property (!(frame_sync_first && frame_sync_second))
    else $error("both syncs high");
  AST_TXD_AT_RISE:
    assert property ($changed(txd) |-> $rose(sclk)
      || !(frame_sync_first || frame_sync_second)) else $error("txd moved");
  AST_SYNC_AT_RISE:
    assert property ($rose(frame_sync_first) || $rose(frame_sync_second)
      |-> $rose(sclk)) else $error("sync rose off clock rise");
  AST_IRQ_AT_END:
    assert property ($fell(frame_sync_second) && chan_ext_free != 2'h3
      |-> ##[0:1] codec_irq) else $error("no frame end irq");
  AST_IRQ_PULSE:
    assert property (codec_irq |=> !codec_irq) else $error("irq too long");
  AST_IRQ_CAUSE:
    assert property (codec_irq && frame_end_irq_line |-> $past(frame_sync_second)
      || $past(frame_sync_second, 2)) else $error("stray irq");
  AST_OWN_ON:
    assert property ((chan_ext_free != 2'h3) [*2] |-> int_vector_owned)
    else $error("vector not owned");
  AST_RD_HOLD:
    assert property (!$past(ext_rd) |-> $stable(ext_rdata))
    else $error("read data moved");
  // main scenarios reached
  COV_ENABLE_IRQ: cover property (codec_irq && !frame_end_irq_line);
  COV_CH0: cover property ($fell(frame_sync_first));
  COV_FULL: cover property (!ext_wait_n);
  COV_LONG: cover property ($fell(frame_sync_first) &&
                            $rose(frame_sync_second));
endmodule : dccsp_props

bind dccsp_top dccsp_props props_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .ext_rd(ext_rd),
  .ext_rdata(ext_rdata), .ext_wait_n(ext_wait_n), .sclk(sclk), .txd(txd),
  .frame_sync_first(frame_sync_first), .frame_sync_second(frame_sync_second),
  .frame_end_irq_line(frame_end_irq_line), .codec_irq(codec_irq),
  .int_vector_owned(int_vector_owned), .chan_ext_free(chan_ext_free));
`default_nettype wire

//--- tb/dccsp_codec.sv
// behavioural codec on the far side of the serial link
`timescale 1ns/100ps
`default_nettype none
module dccsp_codec (
  // link from the port
  input  wire logic        sclk,
  input  wire logic        txd,
  input  wire logic        frame_sync_first,
  input  wire logic        frame_sync_second,
  // answer pattern and pace
  input  wire logic        slow,
  input  wire logic [15:0] reply_word,
  // line back and last word heard
  output var  logic        rxd,
  output var  logic [15:0] heard
);
  logic [3:0] idx = 4'hf;      // reply bit sent next
  initial begin
    rxd = 1'h0;
    heard = 16'h0000;
  end
  // any rising sync restarts the reply word, even after a cut frame
  always @(posedge frame_sync_first or posedge frame_sync_second) begin
    idx = 4'hf;
  end
  // next reply bit after each rise, late when slow
  always @(posedge sclk) begin
    #(slow ? 7 : 1);
    if (frame_sync_first || frame_sync_second) begin
      rxd = reply_word[idx];
      idx = idx - 4'h1;
    end else begin
      rxd = !rxd; // released line keeps no value
    end
  end
  // take the port's bits on the falling clock
  always @(negedge sclk) begin
    #1;
    if (frame_sync_first || frame_sync_second) heard = {heard[14:0], txd};
  end
endmodule : dccsp_codec
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench of the codec serial port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // drive side
  logic        clk_sys = 1'h0;
  logic        sys_rst = 1'h1;
  logic [2:0]  ext_addr = 3'h0;
  logic        ext_wr = 1'h0;
  logic        ext_rd = 1'h0;
  logic [15:0] ext_wdata = 16'h0000;
  logic        irq_pin = 1'h0;
  logic        slow = 1'h0;
  // observed side
  logic [15:0] ext_rdata, wait_cfg, heard;
  logic [1:0]  free;
  logic        wait_n, sclk, txd, rxd, fs0, fs1, irq, owned, mulaw;
  int          num_errors = 0;
  int          n_compared = 0;
  dccsp_top dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ext_addr(ext_addr),
    .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata), .ext_wait_n(wait_n), .sclk(sclk), .txd(txd),
    .rxd(rxd), .frame_sync_first(fs0), .frame_sync_second(fs1),
    .frame_end_irq_line(irq_pin), .codec_irq(irq), .int_vector_owned(owned),
    .chan_ext_free(free), .wait_state_cfg(wait_cfg), .mulaw_sel(mulaw));
  dccsp_codec codec (
    .sclk(sclk), .txd(txd), .frame_sync_first(fs0), .frame_sync_second(fs1),
    .slow(slow), .reply_word(16'h9621), .rxd(rxd), .heard(heard));
  // 100 MHz clock
  initial begin
    forever #5 clk_sys = !clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  // a wait that ran out counts and ends the run
  task automatic expire(input int n, input int limit);
    if (n > limit) begin
      chk("wait bound", 16'h0000, 16'h0001);
      give_verdict();
    end
  endtask : expire
  // one access, held to the taking edge; read data left in ext_rdata
  task automatic bus(input logic [2:0] a, input logic w, input logic [15:0] d);
    int n;
    tick();
    for (n = 0; wait_n !== 1'h1; n++) begin
      tick();
      expire(n, 5000);
    end
    ext_addr = a;
    ext_wr = w;
    ext_rd = !w;
    ext_wdata = d;
    tick();
    ext_wr = 1'h0;
    ext_rd = 1'h0;
  endtask : bus
  task automatic wait_irq(input int cnt);
    int n;
    for (n = 0; cnt > 0; n++) begin
      tick();
      if (irq === 1'h1) cnt--;
      expire(n, 4000);
    end
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////
  // idle after reset; freed and unmapped addresses read zero
  task automatic t_reset();
    chk("free", 16'(free), 16'h0003);
    chk("sclk", 16'(sclk), 16'h0000);
    chk("owned", 16'(owned), 16'h0000);
    bus(3'h5, 1'h0, 16'h0000);
    chk("ch0 read", ext_rdata, 16'h0000);
    bus(3'h3, 1'h0, 16'h0000);
    chk("unmapped", ext_rdata, 16'h0000);
  endtask : t_reset
  // ch1 alone, 8 bit, prescale 12, mu-law, irq pin low
  task automatic t_cfg8();
    int n, hit, p, r0, per;
    bus(3'h7, 1'h1, 16'h01c2);
    bus(3'h7, 1'h1, 16'h0a00);
    hit = 0;
    for (n = 0; n < 8; n++) begin
      tick();
      if (irq === 1'h1) hit++;
    end
    chk("enable irq", 16'(hit), 16'h0001);
    chk("owned", 16'(owned), 16'h0001);
    chk("free", 16'(free), 16'h0001);
    chk("mulaw", 16'(mulaw), 16'h0001);
    chk("wait cfg", wait_cfg, 16'h0a00);
    bus(3'h7, 1'h0, 16'h0000);
    chk("cfg read", ext_rdata, 16'h0a00);
    r0 = -1;
    per = 0;
    for (n = 0; n < 40; n++) begin
      p = sclk;
      tick();
      if (sclk === 1'h1 && p == 0) begin
        if (r0 >= 0 && per == 0) per = n - r0;
        r0 = n;
      end
    end
    chk("sclk period", 16'(per), 16'h0008);
  endtask : t_cfg8
  // ch1 byte out and back through a slow codec
  task automatic t_data8();
    int n;
    slow = 1'h1;
    for (n = 0; fs1 !== 1'h1; n++) begin
      tick();
      expire(n, 400);
    end
    bus(3'h6, 1'h1, 16'h12a6);
    wait_irq(2);
    chk("heard byte", {8'h00, heard[7:0]}, 16'h00a6);
    bus(3'h6, 1'h1, 16'h0077);
    wait_irq(2);
    bus(3'h6, 1'h0, 16'h0000);
    chk("ch1 read", ext_rdata, 16'h1296);
  endtask : t_data8
  // both channels 16 bit, pin high, write fifo pushed past full
  task automatic t_fifo16();
    int n, hit;
    slow = 1'h0;
    irq_pin = 1'h1;
    bus(3'h7, 1'h1, 16'h00f7);
    bus(3'h7, 1'h1, 16'h0a00);
    hit = 0;
    for (n = 0; n < 12; n++) begin
      tick();
      if (irq === 1'h1) hit++;
    end
    chk("no enable irq", 16'(hit), 16'h0000);
    bus(3'h5, 1'h1, 16'hc381);
    tick();
    ext_addr = 3'h6;
    ext_wdata = 16'h5a0f;
    ext_wr = 1'h1;
    hit = 0;
    for (n = 0; n < 24; n++) begin
      tick();
      if (wait_n === 1'h0) hit++;
    end
    ext_wr = 1'h0;
    chk("fifo refused", 16'(hit > 0), 16'h0001);
    hit = 0;
    for (n = 0; n < 20; n++) begin
      wait_irq(1);
      if (heard === 16'h5a0f) hit++;
    end
    chk("ch1 word sent", 16'(hit > 0), 16'h0001);
    chk("echo", heard, 16'h9621);
  endtask : t_fifo16
  // 64-bit frames, both channels, prescale 0, upper then lower words
  task automatic t_long64();
    int n;
    bus(3'h7, 1'h1, 16'h000b);
    bus(3'h7, 1'h1, 16'h0a00);
    wait_irq(1);
    bus(3'h5, 1'h0, 16'h0000);
    chk("64 ch0 upper in", ext_rdata, 16'h9621);
    bus(3'h5, 1'h1, 16'h3c5a);
    tick();
    bus(3'h5, 1'h0, 16'h0000);
    chk("64 ch0 lower in", ext_rdata, 16'h9621);
    bus(3'h5, 1'h1, 16'he10f);
    bus(3'h6, 1'h1, 16'h7b21);
    bus(3'h6, 1'h1, 16'h48d6);
    for (n = 0; fs0 !== 1'h1; n++) begin
      tick();
      expire(n, 100);
    end
    for (n = 0; fs0 !== 1'h0; n++) begin
      tick();
      expire(n, 1100);
    end
    chk("64 sync swap", 16'(fs1), 16'h0001);
    chk("64 ch0 stage two", heard, 16'he10f);
    wait_irq(1);
    chk("64 ch1 stage two", heard, 16'h48d6);
  endtask : t_long64
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) tick();
    sys_rst = 1'h0;
    tick();
    t_reset();
    t_cfg8();
    t_data8();
    t_fifo16();
    t_long64();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
